// ==== sensor_setup_core.sv ====
// setup word with its serial port, plus the common-mode self-test stepper
// assumes serial mode 0, MSB first, 16 bits per frame, word taken at select release;
// the stimulus pin is shared with serial data out and is only watched while select is high;
// stepping is paced by synchronised pin edges alone, the analog shift itself lives elsewhere
`default_nettype none

module sensor_setup_core
    import sensor_setup_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              sclk,
    input  wire logic              select_n,
    input  wire logic              sdi,
    input  wire logic              serial_out_stimulus_pin_in,
    output logic                   serial_out_stimulus_pin_out,
    output logic                   serial_out_stimulus_pin_oe,
    output logic [WORD_W-1:0]      sensor_setup_word,
    output logic                   measure_select,
    output logic                   current_route_select,
    output logic [1:0]             current_level_select,
    output logic                   gain_high,
    output logic [2:0]             common_level_field,
    output logic                   output_common_select,
    output logic                   selftest_enable,
    output logic                   cm_step_up,
    output logic                   cm_step_down,
    output logic signed [7:0]      cm_shift_pct,
    output logic                   selftest_halted
);
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;

    // lanes: 0 sclk, 1 select (inverted), 2 sdi, 3 stimulus pin; select goes in inverted
    // so its reset level matches the idle pin and no false frame end follows reset
    pin_sync #(.WIDTH(4)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin_in  ({serial_out_stimulus_pin_in, sdi, ~select_n, sclk}),
        .level   (lvl),
        .rise    (rise),
        .fall    (fall)
    );

    // edge pulses and levels from the synchroniser, named for the frame and stepper logic
    logic            sclk_rise;
    logic            sclk_fall;
    logic            sel_active;
    logic            sel_start;
    logic            sel_end;
    logic            sdi_lvl;
    logic            stim_rise;
    assign sclk_rise  = rise[0];
    assign sclk_fall  = fall[0];
    assign sel_active = lvl[1];
    assign sel_start  = rise[1];
    assign sel_end    = fall[1];
    assign sdi_lvl    = lvl[2];
    // falling edges of the pin are never looked at by the stepper
    assign stim_rise  = rise[3] & ~lvl[1];

    // serial shift in: bits are taken only inside a frame
    logic [WORD_W-1:0] shift_reg;
    logic [4:0]        bit_cnt_reg;

    // one frame is exactly one word; the count saturates one past it so that a long
    // frame can never wrap back round to a valid length
    localparam logic [4:0] FRAME_BITS = 5'(WORD_W);
    localparam logic [4:0] FRAME_OVER = 5'(WORD_W + 1);

    // sample data on rising serial clock inside the frame;
    // a fresh frame restarts the count and shifts all sixteen bits anew
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg   <= '0;
            bit_cnt_reg <= 5'h00;
        end else if (sel_start) begin
            bit_cnt_reg <= 5'h00;
        end else if (sel_active && sclk_rise) begin
            shift_reg <= {shift_reg[WORD_W-2:0], sdi_lvl};
            if (bit_cnt_reg != FRAME_OVER) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // a frame counts only with exactly 16 clocks; short or long frames are dropped;
    // the write lands about three clocks after select rises, once the last bit is in
    logic word_write;
    assign word_write = sel_end && (bit_cnt_reg == FRAME_BITS);

    // setup word register
    // a dropped frame leaves the old word and its decode untouched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sensor_setup_word <= SETUP_RESET;
        end else if (word_write) begin
            sensor_setup_word <= shift_reg;
        end
    end

    // decoded analog controls, registered so each output leaves a flop
    // reserved bits live only in the word and are read back as written
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            measure_select       <= SETUP_RESET[MEASURE_BIT];
            current_route_select <= SETUP_RESET[ROUTE_BIT];
            current_level_select <= SETUP_RESET[CURRENT_HI:CURRENT_LO];
            gain_high            <= SETUP_RESET[GAIN_BIT];
            common_level_field   <= SETUP_RESET[COMMON_HI:COMMON_LO];
            output_common_select <= SETUP_RESET[OUT_COMMON_BIT];
            selftest_enable      <= SETUP_RESET[SELFTEST_BIT];
        end else if (word_write) begin
            measure_select       <= shift_reg[MEASURE_BIT];
            current_route_select <= shift_reg[ROUTE_BIT];
            current_level_select <= shift_reg[CURRENT_HI:CURRENT_LO];
            gain_high            <= shift_reg[GAIN_BIT];
            // taken as written; keeping the pH value is the host's job
            common_level_field   <= shift_reg[COMMON_HI:COMMON_LO];
            output_common_select <= shift_reg[OUT_COMMON_BIT];
            selftest_enable      <= shift_reg[SELFTEST_BIT];
        end
    end

    // serial shift out on the shared pin
    logic [WORD_W-1:0] out_shift_reg;

    // read back the current word; next bit launched on falling serial clock, so the host
    // samples a settled bit; the pin is released outside a frame for the stimulus edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_shift_reg               <= '0;
            serial_out_stimulus_pin_out <= 1'b0;
            serial_out_stimulus_pin_oe  <= 1'b0;
        end else if (sel_start) begin
            out_shift_reg               <= {sensor_setup_word[WORD_W-2:0], 1'b0};
            serial_out_stimulus_pin_out <= sensor_setup_word[WORD_W-1];
            serial_out_stimulus_pin_oe  <= 1'b1;
        end else if (sel_end) begin
            serial_out_stimulus_pin_oe  <= 1'b0;
            serial_out_stimulus_pin_out <= 1'b0;
        end else if (sel_active && sclk_fall) begin
            serial_out_stimulus_pin_out <= out_shift_reg[WORD_W-1];
            out_shift_reg               <= {out_shift_reg[WORD_W-2:0], 1'b0};
        end
    end

    // self-test stepper
    stepper_state_t state_reg;
    logic [1:0]     step_cnt_reg;

    // stepping order keyed on how many counted edges came before; state and count move
    // together, so the fourth edge wraps the count to zero exactly as the sequence halts
    function automatic stepper_state_t next_step_state(input logic [1:0] count);
        stepper_state_t next_state;
        case (count)
            2'h0:    next_state = ST_STEP_UP;
            2'h1:    next_state = ST_GAP;
            2'h2:    next_state = ST_STEP_DOWN;
            2'h3:    next_state = ST_HALTED;
            default: next_state = ST_IDLE;
        endcase
        return next_state;
    endfunction : next_step_state

    // signed shift of the common level; idle, gap and halt all sit at the programmed level
    function automatic logic signed [7:0] shift_for_state(input stepper_state_t st_in);
        logic signed [7:0] shift;
        case (st_in)
            ST_STEP_UP:   shift = STEP_PCT;
            ST_STEP_DOWN: shift = -STEP_PCT;
            default:      shift = 8'sh00;
        endcase
        return shift;
    endfunction : shift_for_state

    // any accepted word rewrites the enable, which restarts the count from zero;
    // once halted the count stands still until such a rewrite arrives
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= ST_IDLE;
            step_cnt_reg <= 2'h0;
        end else if (word_write) begin
            step_cnt_reg <= 2'h0;
            state_reg    <= shift_reg[SELFTEST_BIT] ? ST_ARMED : ST_IDLE;
        end else if (!selftest_enable) begin
            state_reg    <= ST_IDLE;
            step_cnt_reg <= 2'h0;
        end else if (stim_rise) begin
            case (state_reg)
                ST_ARMED, ST_STEP_UP, ST_GAP, ST_STEP_DOWN: begin
                    state_reg    <= next_step_state(step_cnt_reg);
                    step_cnt_reg <= step_cnt_reg + 2'h1;
                end
                ST_HALTED: begin
                    state_reg <= ST_HALTED;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // step outputs follow the state one cycle later, glitch free from flops
    // the halt flag stays up until a word rewrite moves the state on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cm_step_up      <= 1'b0;
            cm_step_down    <= 1'b0;
            cm_shift_pct    <= 8'sh00;
            selftest_halted <= 1'b0;
        end else begin
            cm_step_up      <= (state_reg == ST_STEP_UP);
            cm_step_down    <= (state_reg == ST_STEP_DOWN);
            selftest_halted <= (state_reg == ST_HALTED);
            // a step cut short by a rewrite falls back to zero one cycle after the state
            cm_shift_pct    <= shift_for_state(state_reg);
        end
    end
endmodule : sensor_setup_core

`default_nettype wire

// ==== sensor_setup_pkg.sv ====
// constants for the sensor setup word, its serial port and the self-test stepper
// assumes one 200 MHz system clock and a host that frames 16-bit words with a select line
// How it works
// - bit 15 picks temperature mode, 14 current route, 13:12 current, 11 gain.
// - with self-test enable clear, common level stays put and the pin is ignored.
// - enabled, first rising pin edge starts the upward step; second ends it.
// - third rising edge starts the downward step; fourth ends it and halts.
// - after halting, edges are ignored until self-test enable is written 1 again.
// - each step moves the common level by about five percent of reference.
`default_nettype none

package sensor_setup_pkg;
    localparam int          WORD_W          = 16;
    localparam logic [15:0] SETUP_RESET     = 16'h0000;
    // field positions inside the setup word
    localparam int          MEASURE_BIT     = 15;
    localparam int          ROUTE_BIT       = 14;
    localparam int          CURRENT_HI      = 13;
    localparam int          CURRENT_LO      = 12;
    localparam int          GAIN_BIT        = 11;
    localparam int          COMMON_HI       = 10;
    localparam int          COMMON_LO       = 8;
    localparam int          OUT_COMMON_BIT  = 7;
    localparam int          SELFTEST_BIT    = 6;
    // current codes and gain
    localparam logic [1:0]  CURRENT_100UA   = 2'h0;
    localparam logic [1:0]  CURRENT_1MA     = 2'h2;
    localparam int          GAIN_HIGH_VV    = 10;
    // self-test step size, percent of reference, signed
    localparam logic signed [7:0] STEP_PCT  = 8'sh05;
    localparam int          SYNC_STAGES     = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_STEP_UP,
        ST_GAP,
        ST_STEP_DOWN,
        ST_HALTED
    } stepper_state_t;
endpackage : sensor_setup_pkg

`default_nettype wire

// ==== pin_sync.sv ====
// two-flop synchroniser with rise and fall detection, one lane per bit
// assumes asynchronous pins; edge pulses are one clk cycle long
`default_nettype none

module pin_sync
    import sensor_setup_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] last_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;
endmodule : pin_sync

`default_nettype wire

// ==== sensor_setup_monitor.sv ====
// checker for the setup core: field decode, step levels and what may start them
// assumes it is bound to sensor_setup_core and sees only that module's ports
`default_nettype none

module sensor_setup_monitor
    import sensor_setup_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              select_n,
    input wire logic              serial_out_stimulus_pin_in,
    input wire logic [WORD_W-1:0] sensor_setup_word,
    input wire logic              measure_select,
    input wire logic              current_route_select,
    input wire logic [1:0]        current_level_select,
    input wire logic              gain_high,
    input wire logic [2:0]        common_level_field,
    input wire logic              output_common_select,
    input wire logic              selftest_enable,
    input wire logic              cm_step_up,
    input wire logic              cm_step_down,
    input wire logic signed [7:0] cm_shift_pct,
    input wire logic              selftest_halted
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] quiet_reg;
    // cycles with no pin change and no frame; nothing may step once such a stretch reaches eight cycles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) quiet_reg <= 4'h0;
        else if ($changed(serial_out_stimulus_pin_in) || !select_n) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
    end
    a_field_decode: assert property ({measure_select, current_route_select,
        current_level_select, gain_high, common_level_field, output_common_select,
        selftest_enable} == sensor_setup_word[15:6]) else $error("decode mismatch");
    a_off_idle: assert property (!selftest_enable && !$past(selftest_enable)
        |-> !cm_step_up && !cm_step_down && cm_shift_pct == 8'sh00) else $error("moved off");
    a_up_size: assert property (cm_step_up |-> cm_shift_pct == 8'sh05)
        else $error("up step size wrong");
    a_down_size: assert property (cm_step_down |-> cm_shift_pct == 8'shFB)
        else $error("down step size wrong");
    a_up_cause: assert property ($rose(cm_step_up) |-> $past(serial_out_stimulus_pin_in, 4)
        || $past(serial_out_stimulus_pin_in, 5)) else $error("up step without edge");
    a_down_cause: assert property ($rose(cm_step_down) |-> $past(serial_out_stimulus_pin_in, 4)
        || $past(serial_out_stimulus_pin_in, 5)) else $error("down step without edge");
    a_halt_after_down: assert property ($rose(selftest_halted) |-> $past(cm_step_down))
        else $error("halt not after down step");
    a_halt_quiet: assert property (selftest_halted |-> !cm_step_up && !cm_step_down)
        else $error("step while halted");
    a_edge_only: assert property (quiet_reg >= 4'h8
        |-> $stable({cm_step_up, cm_step_down, selftest_halted})) else $error("step unprompted");
endmodule : sensor_setup_monitor

bind sensor_setup_core sensor_setup_monitor sensor_setup_monitor_i (.clk, .reset_n, .select_n,
    .serial_out_stimulus_pin_in, .sensor_setup_word, .measure_select, .current_route_select,
    .current_level_select, .gain_high, .common_level_field, .output_common_select,
    .selftest_enable, .cm_step_up, .cm_step_down, .cm_shift_pct, .selftest_halted);

`default_nettype wire

// ==== host_model.sv ====
// host model: drives the serial port and the stimulus pin from the falling clk edge
// assumes a 200 MHz clk; 13 clk high and 12 clk low give a 125 ns serial clock
`default_nettype none

module host_model (
    input  wire logic clk,
    input  wire logic pin,
    output var logic  sclk,
    output var logic  select_n,
    output var logic  sdi,
    output var logic  stim
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] PH_COMMON = 3'h2;
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        sdi = 1'b0;
        stim = 1'b0;
    end
    task automatic wait_fall(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_fall
    // one frame of n bits, readback taken on each serial rise
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        logic [15:0] d;
        d = {w[15:11], PH_COMMON, w[7:0]};
        r = 16'h0000;
        select_n = 1'b0;
        wait_fall(4);
        for (int i = 0; i < n; i++) begin
            sdi = (i < 16) ? d[15-i] : 1'b0; // clocks past one word carry zeros
            wait_fall(12);
            sclk = 1'b1;
            r = {r[14:0], pin};
            wait_fall(13);
            sclk = 1'b0;
        end
        wait_fall(12);
        select_n = 1'b1;
        sdi = ~sdi; // released line: no stale level left behind
        wait_fall(12);
    endtask : xfer
    // held past the synchroniser on both levels
    task automatic pulse();
        stim = 1'b1;
        wait_fall(8);
        stim = 1'b0;
        wait_fall(8);
    endtask : pulse
endmodule : host_model

`default_nettype wire

// ==== testbench.sv ====
// top bench: host model facing the setup core, word writes and stimulus runs
// assumes the host model paces every transfer from the falling clk edge
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        reset_n;
    logic [15:0] rd;
    int          num_errors = 0;
    int          checks_done = 0;
    logic [15:0] seq [5] = '{16'h040A, 16'h0000, 16'h03F6, 16'h0001, 16'h0001};
    wire logic        sclk, select_n, sdi, stim, pin_out, pin_oe, pin;
    wire logic [15:0] word;
    wire logic [9:0]  dec;
    wire logic [10:0] st;
    // shared pin: the core wins while it drives
    assign pin = pin_oe ? pin_out : stim;
    host_model host_model_i (.clk(clk), .pin(pin), .sclk(sclk), .select_n(select_n),
        .sdi(sdi), .stim(stim));
    sensor_setup_core sensor_setup_core_i (.clk(clk), .reset_n(reset_n), .sclk(sclk),
        .select_n(select_n), .sdi(sdi), .serial_out_stimulus_pin_in(pin),
        .serial_out_stimulus_pin_out(pin_out), .serial_out_stimulus_pin_oe(pin_oe),
        .sensor_setup_word(word), .measure_select(dec[9]), .current_route_select(dec[8]),
        .current_level_select(dec[7:6]), .gain_high(dec[5]), .common_level_field(dec[4:2]),
        .output_common_select(dec[1]), .selftest_enable(dec[0]), .cm_step_up(st[10]),
        .cm_step_down(st[9]), .cm_shift_pct(st[8:1]), .selftest_halted(st[0]));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // about 3000 clk expected; a hang is cut well beyond that
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check(word, 16'h0000);
        check(16'(st), 16'h0000);
        repeat (3) @(negedge clk);
        // self-test off: pulses must not move the common level
        host_model_i.xfer(16'h8280, 16, rd);
        check(rd, 16'h0000);
        check(word, 16'h8280);
        check(16'(dec), 16'h020A);
        repeat (4) host_model_i.pulse();
        check(16'(st), 16'h0000);
        // short and long frames are dropped without trace
        host_model_i.xfer(16'hAA40, 15, rd);
        check(word, 16'h8280);
        host_model_i.xfer(16'hAA40, 17, rd);
        check(word, 16'h8280);
        host_model_i.xfer(16'hAA40, 16, rd);
        check(rd, 16'h8280);
        check(16'(dec), 16'h02A9);
        // four counted edges, then one that must be ignored
        for (int i = 0; i < 5; i++) begin
            host_model_i.pulse();
            check(16'(st), seq[i]);
        end
        host_model_i.xfer(16'hAA40, 16, rd);
        check(16'(st), 16'h0000);
        host_model_i.pulse();
        check(16'(st), 16'h040A);
        // rewriting the enable mid-step restarts at the first step
        host_model_i.xfer(16'hAA40, 16, rd);
        check(16'(st), 16'h0000);
        host_model_i.pulse();
        check(16'(st), 16'h040A);
        // clearing the enable mid-step drops the step at once
        host_model_i.xfer(16'h8280, 16, rd);
        check(16'(st), 16'h0000);
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
